// ### logic/fsr_readback.sv
// What this block does
// - Armed fuse read at pointer 0x0003 returns all high fuse bits.
// - Armed fuse read at 0x0002 returns extended fuse, low nibble only.
// - Returned fuse and lock bits: 0 programmed, 1 unprogrammed.
// - Armed signature read returns the row byte the pointer selects.
// - Command bits self-clear after the read or three idle cycles; an armed store waits four.
// - With command bits clear, load reads ordinary flash contents.
// - Identity bytes sit at pointers 0x0000, 0x0002, 0x0004.
// - Oscillator calibration sits at pointer 0x0001.
// - Temperature offset and gain sit at 0x0005 and 0x0007.
// - A system reset during a flash write lets the write finish.
// - Erase and write take 3.7 ms, the low end of the 3.7 to 4.5 ms range.
// - READ_WHILE_WRITE_SECTION busy blocks READ_WHILE_WRITE_SECTION fetches, not loads; re-enable command clears it.
// - During erase or write only the no-READ_WHILE_WRITE_SECTION section is fetchable.
// - Low fuse byte reads armed with pointer 0x0000.
// - Lock bits read armed with pointer 0x0001.
`include "fsr_cfg.svh"

module fsr_readback
    import fsr_pkg::*;
#(
    parameter logic [7:0] SIG_ID1 = 8'h11, // Arbitrary identity value.
    parameter logic [7:0] SIG_ID2 = 8'h22, // Arbitrary identity value.
    parameter logic [7:0] SIG_ID3 = 8'h33, // Arbitrary identity value.
    parameter int unsigned WRITE_CYC = `FSR_WRITE_CYC,
    parameter int unsigned PTR_W = 16,
    parameter logic [PTR_W-1:0] NO_READ_WHILE_WRITE_SECTION_START = 16'h3800
) (
    // Clock and resets.
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic por_n,
    // Control/status register write from the CPU.
    input wire logic csr_wr,
    input wire logic [7:0] csr_wdata,
    output logic [7:0] self_prog_control_status,
    // Instruction strobes and pointer.
    input wire logic lpm_req,
    input wire logic spm_req,
    input wire logic [PTR_W-1:0] ptr,
    input wire logic eeprom_write_pending,
    // Flash array read path.
    input wire logic [7:0] flash_rdata,
    output logic [7:0] lpm_rdata,
    output logic lpm_valid,
    // Fetch gating.
    input wire logic [PTR_W-1:0] fetch_addr,
    output logic fetch_allowed,
    // Nonvolatile contents, 0 means programmed.
    input wire logic [7:0] fuse_low,
    input wire logic [7:0] high_fuse_byte,
    input wire logic [7:0] extended_fuse_byte,
    input wire logic [7:0] lock_bits,
    input wire logic [7:0] osc_cal_byte,
    input wire logic [7:0] temp_sensor_offset_byte,
    input wire logic [7:0] temp_sensor_gain_byte,
    // Flash programming strobes.
    output logic flash_prog_start,
    output logic flash_prog_busy
);
    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic prog_op_enable_reg;
    logic lock_fuse_read_select_reg;
    logic signature_read_select_reg;
    logic page_erase_cmd_reg;
    logic page_write_cmd_reg;
    logic rww_reenable_cmd_reg;
    logic rww_busy_flag_reg;
    logic [7:0] lpm_rdata_reg;
    logic lpm_valid_reg;
    logic ld_open, ld_exp, st_open, st_exp, wr_busy, wr_done;

    wire logic wr_en = csr_wdata[`FSR_BIT_PROG_EN];
    // EEPROM write blocks programming, fuse reads and signature reads.
    wire logic arm_ok = csr_wr && wr_en && !prog_op_enable_reg &&
                        !eeprom_write_pending;
    wire logic arm_fuse = arm_ok && csr_wdata[`FSR_BIT_LOCK_FUSE_RD];
    wire logic arm_sig = arm_ok && csr_wdata[`FSR_BIT_SIG_RD];
    wire logic arm_read = arm_fuse || arm_sig;
    wire logic arm_store = arm_ok && !arm_read;
    wire logic read_armed = prog_op_enable_reg &&
        (lock_fuse_read_select_reg || signature_read_select_reg);
    wire logic store_armed = prog_op_enable_reg && !read_armed &&
                             !wr_busy;
    wire logic read_hit = read_armed && ld_open && lpm_req;
    wire logic store_hit = store_armed && st_open && spm_req;
    wire logic is_prog = page_erase_cmd_reg || page_write_cmd_reg;
    wire logic prog_go = store_hit && is_prog;
    wire logic reen_go = store_hit && rww_reenable_cmd_reg;
    wire logic store_end = store_hit || (store_armed && st_exp);
    wire logic read_end = read_hit || (read_armed && ld_exp);

    // ------------------------------------------------------------
    // Readback mux
    // ------------------------------------------------------------
    logic [7:0] fuse_byte, sig_byte, rd_byte;
    always_comb begin
        unique case (ptr)
            `FSR_PTR_FUSE_LOW: fuse_byte = fuse_low;
            `FSR_PTR_LOCK: fuse_byte = lock_bits;
            `FSR_PTR_FUSE_EXT:
                fuse_byte = extended_fuse_byte | ~`FSR_EXT_FUSE_MASK;
            `FSR_PTR_FUSE_HIGH: fuse_byte = high_fuse_byte;
            default: fuse_byte = 8'hFF;
        endcase
    end
    always_comb begin
        unique case (ptr)
            `FSR_PTR_SIG_ID1: sig_byte = SIG_ID1;
            `FSR_PTR_OSC_CAL: sig_byte = osc_cal_byte;
            `FSR_PTR_SIG_ID2: sig_byte = SIG_ID2;
            `FSR_PTR_SIG_ID3: sig_byte = SIG_ID3;
            `FSR_PTR_TS_OFFSET: sig_byte = temp_sensor_offset_byte;
            `FSR_PTR_TS_GAIN: sig_byte = temp_sensor_gain_byte;
            default: sig_byte = 8'hFF;
        endcase
    end
    // Ordinary flash read once the read window is gone.
    assign rd_byte = !read_hit ? flash_rdata :
                     (signature_read_select_reg ? sig_byte :
                      fuse_byte);

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    fsr_window_timer #(.LEN(`FSR_LOAD_WINDOW)) u_load_win (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(arm_read),
        .stop(read_hit),
        .open_win(ld_open),
        .expired(ld_exp)
    );
    fsr_window_timer #(.LEN(`FSR_STORE_WINDOW)) u_store_win (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(arm_store),
        .stop(store_hit),
        .open_win(st_open),
        .expired(st_exp)
    );
    fsr_write_timer #(.WRITE_CYC(WRITE_CYC)) u_write (
        .clk_sys(clk_sys),
        .por_n(por_n),
        .start(prog_go),
        .busy(wr_busy),
        .done(wr_done)
    );

    // ------------------------------------------------------------
    // Command bits and READ_WHILE_WRITE_SECTION busy
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prog_op_enable_reg <= 1'b0;
            lock_fuse_read_select_reg <= 1'b0;
            signature_read_select_reg <= 1'b0;
            page_erase_cmd_reg <= 1'b0;
            page_write_cmd_reg <= 1'b0;
            rww_reenable_cmd_reg <= 1'b0;
        end else if (arm_ok) begin
            prog_op_enable_reg <= 1'b1;
            lock_fuse_read_select_reg <= csr_wdata[`FSR_BIT_LOCK_FUSE_RD];
            signature_read_select_reg <= csr_wdata[`FSR_BIT_SIG_RD];
            page_erase_cmd_reg <= csr_wdata[`FSR_BIT_PAGE_ERASE];
            page_write_cmd_reg <= csr_wdata[`FSR_BIT_PAGE_WRITE];
            rww_reenable_cmd_reg <= csr_wdata[`FSR_BIT_RWW_REEN];
        end else if (read_end || wr_done ||
                     (store_end && !prog_go)) begin
            prog_op_enable_reg <= 1'b0;
            lock_fuse_read_select_reg <= 1'b0;
            signature_read_select_reg <= 1'b0;
            page_erase_cmd_reg <= 1'b0;
            page_write_cmd_reg <= 1'b0;
            rww_reenable_cmd_reg <= 1'b0;
        end
    end

    // Busy is set by a program start and held while the write timer runs,
    // so a system reset mid-write cannot reopen the READ_WHILE_WRITE_SECTION section early.
    // Only a re-enable after the write, or a system reset, clears it; set wins over clear.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rww_busy_flag_reg <= 1'b0;
        end else if (prog_go || wr_busy) begin
            rww_busy_flag_reg <= 1'b1;
        end else if (reen_go && !wr_busy) begin
            rww_busy_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lpm_rdata_reg <= 8'h00;
            lpm_valid_reg <= 1'b0;
        end else begin
            lpm_valid_reg <= lpm_req;
            if (lpm_req) begin
                lpm_rdata_reg <= rd_byte;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign lpm_rdata = lpm_rdata_reg;
    assign lpm_valid = lpm_valid_reg;
    assign flash_prog_start = prog_go;
    assign flash_prog_busy = wr_busy;
    // Fetch outside the no-READ_WHILE_WRITE_SECTION section is refused while READ_WHILE_WRITE_SECTION is busy.
    assign fetch_allowed = !(rww_busy_flag_reg || wr_busy) ||
                           (fetch_addr >= NO_READ_WHILE_WRITE_SECTION_START);
    assign self_prog_control_status = {1'b0, rww_busy_flag_reg,
        signature_read_select_reg, rww_reenable_cmd_reg,
        lock_fuse_read_select_reg, page_write_cmd_reg,
        page_erase_cmd_reg, prog_op_enable_reg};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_fuse_high_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        lpm_req && read_hit && lock_fuse_read_select_reg &&
        ptr == `FSR_PTR_FUSE_HIGH |=> lpm_rdata == $past(high_fuse_byte))
        else $error("High fuse readback wrong.");
    a_fuse_ext_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        read_hit && lock_fuse_read_select_reg && ptr == `FSR_PTR_FUSE_EXT
        |=> lpm_rdata[3:0] == $past(extended_fuse_byte[3:0]))
        else $error("Extended fuse readback wrong.");
    a_fuse_low_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        read_hit && lock_fuse_read_select_reg && ptr == `FSR_PTR_FUSE_LOW
        |=> lpm_rdata == $past(fuse_low))
        else $error("Low fuse readback wrong.");
    a_lock_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        read_hit && lock_fuse_read_select_reg && ptr == `FSR_PTR_LOCK
        |=> lpm_rdata == $past(lock_bits))
        else $error("Lock readback wrong.");
    a_sig_cal_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        read_hit && signature_read_select_reg && ptr == `FSR_PTR_OSC_CAL
        |=> lpm_rdata == $past(osc_cal_byte))
        else $error("Calibration readback wrong.");
    a_sig_ts_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        read_hit && signature_read_select_reg && ptr == `FSR_PTR_TS_GAIN
        |=> lpm_rdata == $past(temp_sensor_gain_byte))
        else $error("Gain readback wrong.");
    a_sig_off_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        read_hit && signature_read_select_reg && ptr == `FSR_PTR_TS_OFFSET
        |=> lpm_rdata == $past(temp_sensor_offset_byte))
        else $error("Offset readback wrong.");
    a_sig_id_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        read_hit && signature_read_select_reg && ptr == `FSR_PTR_SIG_ID1
        |=> lpm_rdata == SIG_ID1)
        else $error("Identity readback wrong.");
    a_arm_timeout: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        arm_read ##1 !lpm_req [*3] |=> !prog_op_enable_reg)
        else $error("Read arm did not time out.");
    a_read_clear: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        read_hit |=> !prog_op_enable_reg)
        else $error("Command bits kept after read.");
    a_plain_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        lpm_req && !prog_op_enable_reg |=> lpm_rdata == $past(flash_rdata))
        else $error("Plain load not from flash.");
    a_fetch_block: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_busy && fetch_addr < NO_READ_WHILE_WRITE_SECTION_START |-> !fetch_allowed)
        else $error("READ_WHILE_WRITE_SECTION fetch allowed during write.");
    a_busy_hold: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        prog_go |=> rww_busy_flag_reg [*8])
        else $error("Busy flag dropped early.");
    a_busy_during_write: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_busy |=> rww_busy_flag_reg)
        else $error("Busy flag low while write runs.");
    a_write_end: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_done && prog_op_enable_reg |=> !prog_op_enable_reg)
        else $error("Enable kept after write end.");
    c_fuse_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
        arm_fuse ##[1:3] read_hit);
    c_sig_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
        arm_sig ##[1:3] read_hit);
    c_prog_start: cover property (@(posedge clk_sys) disable iff (!rst_n)
        prog_go);
    c_read_expire: cover property (@(posedge clk_sys) disable iff (!rst_n)
        read_armed && ld_exp);
    c_rww_clear: cover property (@(posedge clk_sys) disable iff (!rst_n)
        reen_go && !wr_busy);
endmodule

// ### logic/fsr_cfg.svh
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH

// Pointer values for fuse and lock reads.
`define FSR_PTR_FUSE_LOW 16'h0000
`define FSR_PTR_LOCK 16'h0001
`define FSR_PTR_FUSE_EXT 16'h0002
`define FSR_PTR_FUSE_HIGH 16'h0003
// Pointer values of the signature row.
`define FSR_PTR_SIG_ID1 16'h0000
`define FSR_PTR_OSC_CAL 16'h0001
`define FSR_PTR_SIG_ID2 16'h0002
`define FSR_PTR_SIG_ID3 16'h0004
`define FSR_PTR_TS_OFFSET 16'h0005
`define FSR_PTR_TS_GAIN 16'h0007
// Control/status bit positions.
`define FSR_BIT_PROG_EN 0
`define FSR_BIT_PAGE_ERASE 1
`define FSR_BIT_PAGE_WRITE 2
`define FSR_BIT_LOCK_FUSE_RD 3
`define FSR_BIT_RWW_REEN 4
`define FSR_BIT_SIG_RD 5
`define FSR_BIT_RWW_BUSY 6
// Window lengths in CPU cycles.
`define FSR_LOAD_WINDOW 3
`define FSR_STORE_WINDOW 4
// Extended fuse meaningful bits mask.
`define FSR_EXT_FUSE_MASK 8'h0F
// Flash write time in microseconds, least and most.
`define FSR_WRITE_MIN_US 3700
`define FSR_WRITE_MAX_US 4500
`define FSR_CLK_MHZ 125
`define FSR_WRITE_CYC (`FSR_WRITE_MIN_US * `FSR_CLK_MHZ)

`endif

// ### logic/fsr_pkg.sv
package fsr_pkg;
    typedef enum logic [1:0] {
        FSR_OP_IDLE,
        FSR_OP_FUSE_RD,
        FSR_OP_SIG_RD,
        FSR_OP_STORE
    } fsr_arm_t;
    typedef enum logic [1:0] {
        FSR_WR_IDLE,
        FSR_WR_BUSY,
        FSR_WR_DONE
    } fsr_wr_t;
endpackage

// ### logic/fsr_window_timer.sv
`include "fsr_cfg.svh"

module fsr_window_timer
    import fsr_pkg::*;
#(
    parameter int unsigned LEN = 3
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control.
    input wire logic start,
    input wire logic stop,
    // Status.
    output logic open_win,
    output logic expired
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    wire logic running = (cnt_reg != 4'h0);

    assign cnt_next = start ? 4'(LEN) :
                      (stop ? 4'h0 : (running ? cnt_reg - 4'h1 : 4'h0));
    assign open_win = running;
    assign expired = (cnt_reg == 4'h1) && !stop && !start;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule

// ### logic/fsr_write_timer.sv
`include "fsr_cfg.svh"

module fsr_write_timer
    import fsr_pkg::*;
#(
    parameter int unsigned WRITE_CYC = `FSR_WRITE_CYC
) (
    // Clock and power-on reset only.
    input wire logic clk_sys,
    input wire logic por_n,
    // Control.
    input wire logic start,
    // Status.
    output logic busy,
    output logic done
);
    fsr_wr_t st_reg;
    logic [19:0] cnt_reg;
    wire logic last = (cnt_reg == 20'h00001);

    assign busy = (st_reg == FSR_WR_BUSY);
    assign done = (st_reg == FSR_WR_DONE);

    // This timer only sees power-on reset, so a system reset mid-write does
    // not cut the flash program pulse short.
    always_ff @(posedge clk_sys or negedge por_n) begin
        if (!por_n) begin
            st_reg <= FSR_WR_IDLE;
            cnt_reg <= 20'h00000;
        end else begin
            unique case (st_reg)
                FSR_WR_IDLE: begin
                    if (start) begin
                        st_reg <= FSR_WR_BUSY;
                        cnt_reg <= 20'(WRITE_CYC);
                    end
                end
                FSR_WR_BUSY: begin
                    cnt_reg <= cnt_reg - 20'h00001;
                    if (last) begin
                        st_reg <= FSR_WR_DONE;
                    end
                end
                FSR_WR_DONE: begin
                    st_reg <= FSR_WR_IDLE;
                end
                default: begin
                    st_reg <= FSR_WR_IDLE;
                end
            endcase
        end
    end
endmodule

// ### verification/fsr_cpu_model.sv
module fsr_cpu_model (
    // Clock and status seen by software.
    input wire logic clk_sys,
    input wire logic [7:0] status,
    // Requests to the block.
    output logic csr_wr,
    output logic [7:0] csr_wdata,
    output logic lpm_req,
    output logic spm_req,
    output logic [15:0] ptr,
    output logic eeprom_write_pending,
    // Flash array stand-in.
    output logic [7:0] flash_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Set by the bench only to provoke a refusal.
    logic ee_busy = 1'b0;
    logic rude = 1'b0;

    assign eeprom_write_pending = ee_busy;
    assign flash_rdata = ptr[7:0] ^ 8'hA5;

    initial begin
        csr_wr = 1'b0;
        csr_wdata = 8'h00;
        lpm_req = 1'b0;
        spm_req = 1'b0;
        ptr = 16'h0000;
    end

    // One timed sequence; a negative gap issues the control write but no load or store.
    // Interrupts are masked implicitly: nothing else runs in between.
    // Only documented pointers are ever read back.
    // The boot lock bits are left alone by this model.
    task automatic op(input logic [7:0] cmd, input logic [15:0] p,
                      input logic use_spm, input int gap);
        int n;
        n = 0;
        while (status[0] !== 1'b0 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        while (ee_busy && !rude && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        @(negedge clk_sys);
        ptr = p;
        csr_wdata = cmd;
        csr_wr = 1'b1;
        @(negedge clk_sys);
        csr_wr = 1'b0;
        if (gap >= 0) begin
            repeat (gap) @(negedge clk_sys);
            lpm_req = !use_spm;
            spm_req = use_spm;
            @(negedge clk_sys);
            lpm_req = 1'b0;
            spm_req = 1'b0;
        end
    endtask
endmodule

// ### verification/fuse_signature_readback_test.sv
`define CHK(nm, got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("BAD %s expected %h seen %h", nm, exp, got); \
        end \
    end

module fuse_signature_readback_test;
    timeunit 1ns;
    timeprecision 1ps;

    // -------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------
    localparam int WCYC = 20;
    localparam int LIMIT = 3000;
    localparam logic [7:0] ID1 = 8'hC1; // Arbitrary identity value.
    localparam logic [7:0] ID2 = 8'hC2; // Arbitrary identity value.
    localparam logic [7:0] ID3 = 8'hC3; // Arbitrary identity value.
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic por_n = 1'b0;
    logic csr_wr, lpm_req, spm_req, eeprom_write_pending;
    logic [7:0] csr_wdata, status, flash_rdata, lpm_rdata;
    logic [15:0] ptr;
    logic [15:0] fetch_addr = 16'h0000;
    logic lpm_valid, fetch_allowed, flash_prog_start, flash_prog_busy;
    logic [7:0] fuse_low = 8'h62;
    logic [7:0] fuse_high = 8'hD9;
    logic [7:0] fuse_ext = 8'h05;
    logic [7:0] lock_bits = 8'hCF;
    logic [7:0] osc_cal = 8'h7B;
    logic [7:0] ts_off = 8'h3C;
    logic [7:0] ts_gain = 8'h96;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int starts = 0;
    int cnt;

    always #4 clk_sys = ~clk_sys;

    fsr_cpu_model i_cpu (
        .clk_sys(clk_sys), .status(status), .csr_wr(csr_wr),
        .csr_wdata(csr_wdata), .lpm_req(lpm_req), .spm_req(spm_req),
        .ptr(ptr), .eeprom_write_pending(eeprom_write_pending),
        .flash_rdata(flash_rdata)
    );

    fsr_readback #(
        .SIG_ID1(ID1), .SIG_ID2(ID2), .SIG_ID3(ID3), .WRITE_CYC(WCYC)
    ) i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .por_n(por_n),
        .csr_wr(csr_wr), .csr_wdata(csr_wdata),
        .self_prog_control_status(status),
        .lpm_req(lpm_req), .spm_req(spm_req), .ptr(ptr),
        .eeprom_write_pending(eeprom_write_pending),
        .flash_rdata(flash_rdata), .lpm_rdata(lpm_rdata),
        .lpm_valid(lpm_valid), .fetch_addr(fetch_addr),
        .fetch_allowed(fetch_allowed), .fuse_low(fuse_low),
        .high_fuse_byte(fuse_high), .extended_fuse_byte(fuse_ext),
        .lock_bits(lock_bits), .osc_cal_byte(osc_cal),
        .temp_sensor_offset_byte(ts_off),
        .temp_sensor_gain_byte(ts_gain),
        .flash_prog_start(flash_prog_start),
        .flash_prog_busy(flash_prog_busy)
    );

    // -------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Armed read; the command bits must be clear once the byte is out.
    task automatic rd(input logic [7:0] cmd, input logic [15:0] p,
                      input int gap, input logic [7:0] exp);
        i_cpu.op(cmd, p, 1'b0, gap);
        `CHK("lpm_valid", lpm_valid, 1'b1)
        if (lpm_valid !== 1'b1)
            @(negedge clk_sys);
        `CHK("lpm_rdata", lpm_rdata, exp)
        `CHK("status", status, 8'h00)
    endtask

    // Counts busy cycles of a write; a reset may be pulsed part way.
    task automatic wr_len(input logic [7:0] cmd, input int rst_at);
        if (flash_prog_busy !== 1'b1)
            @(negedge clk_sys);
        fetch_addr = 16'h0100;
        #1 `CHK("fetch_rww", fetch_allowed, 1'b0)
        fetch_addr = 16'h3800;
        #1 `CHK("fetch_no_read_while_write_section", fetch_allowed, 1'b1)
        cnt = 0;
        while (flash_prog_busy === 1'b1 && cnt < 200) begin
            @(negedge clk_sys);
            cnt++;
            rst_n = (cnt == rst_at) ? 1'b0 : 1'b1;
            if (cnt == rst_at + 2)
                `CHK("busy_after_rst", status[6], 1'b1)
        end
        `CHK("wr_len", cnt >= WCYC - 1 && cnt <= WCYC + 2, 1'b1)
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (flash_prog_start === 1'b1)
            starts++;
        if (cycles == LIMIT) begin
            mismatches++;
            summarize();
        end
    end

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        por_n = 1'b1;
        @(negedge clk_sys);
        `CHK("status_rst", status, 8'h00)
        `CHK("fetch_rst", fetch_allowed, 1'b1)
        rd(8'h09, 16'h0000, 0, 8'h62);
        rd(8'h09, 16'h0001, 2, 8'hCF);
        rd(8'h09, 16'h0002, 1, 8'hF5);
        rd(8'h09, 16'h0003, 0, 8'hD9);
        $display("test fuse_reads done");
        rd(8'h21, 16'h0000, 0, ID1);
        rd(8'h21, 16'h0002, 2, ID2);
        rd(8'h21, 16'h0004, 0, ID3);
        rd(8'h21, 16'h0001, 2, 8'h7B);
        rd(8'h21, 16'h0005, 0, 8'h3C);
        rd(8'h21, 16'h0007, 1, 8'h96);
        $display("test signature_reads done");
        i_cpu.op(8'h21, 16'h0007, 1'b0, -1);
        `CHK("status_armed", status, 8'h21)
        repeat (4) @(negedge clk_sys);
        `CHK("status_expired", status, 8'h00)
        rd(8'h00, 16'h0007, 0, 8'hA2);
        $display("test window_expiry done");
        i_cpu.rude = 1'b1;
        i_cpu.ee_busy = 1'b1;
        i_cpu.op(8'h21, 16'h0000, 1'b0, -1);
        `CHK("status_refused", status, 8'h00)
        i_cpu.ee_busy = 1'b0;
        i_cpu.rude = 1'b0;
        $display("test eeprom_refusal done");
        i_cpu.op(8'h03, 16'h0100, 1'b1, 1);
        `CHK("rww_busy_set", status[6], 1'b1)
        wr_len(8'h03, -1);
        // The enable bit drops one cycle after busy, in the done state.
        @(negedge clk_sys);
        `CHK("enable_done", status[0], 1'b0)
        `CHK("rww_busy_held", status[6], 1'b1)
        i_cpu.op(8'h11, 16'h0100, 1'b1, 0);
        repeat (2) @(negedge clk_sys);
        `CHK("rww_busy_clear", status[6], 1'b0)
        for (int i = 0; i < 4; i++) begin
            i_cpu.op(8'h01, 16'h0100 + 16'(2 * i), 1'b1, 0);
            `CHK("store_no_write", flash_prog_busy, 1'b0)
        end
        i_cpu.op(8'h05, 16'h0100, 1'b1, 2);
        wr_len(8'h05, 5);
        `CHK("prog_starts", starts, 2)
        $display("test flash_writes done");
        summarize();
    end
endmodule
